// ### rtw_pkg.sv
// Constants for the reload timer with watchdog mode: register map, control
// field layout, reset value, service codes and count-clock divide table.
// Assumes a 32-bit APB with word-aligned registers, byte address = 4 x index.
package rtw_pkg;

  // Counter and prescaler widths
  localparam int CNT_W = 8;
  localparam int PRE_W = 12;

  // APB address width and register indices (byte address is index times four)
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_COUNT = 8'h7C;
  localparam logic [7:0] IDX_RELOAD = 8'h7D;
  localparam logic [7:0] IDX_CONTROL = 8'h7E;

  // Control register reset value and field positions
  localparam logic [7:0] CTL_RESET = 8'h10;
  localparam int CTL_MODE_BIT = 7;
  localparam int CTL_NEXT_BIT = 6;
  localparam int CTL_GRUN_BIT = 5;
  localparam int CTL_ONE_BIT = 4;
  localparam int CTL_RUN_BIT = 3;
  localparam int CTL_DIV_MSB = 2;
  localparam int CTL_DIV_LSB = 0;

  // Watchdog start/service codes (low nibble of a counter write)
  localparam logic [3:0] CODE_START = 4'h3;
  localparam logic [3:0] CODE_SERVICE = 4'hC;

  // Count clock divide ratios of the timebase clock, by select code 0..7
  localparam int DIV_0 = 8;
  localparam int DIV_1 = 16;
  localparam int DIV_2 = 32;
  localparam int DIV_3 = 64;
  localparam int DIV_4 = 128;
  localparam int DIV_5 = 256;
  localparam int DIV_6 = 1024;
  localparam int DIV_7 = 4096;

endpackage

// ### rtw_timer.sv
// Reload timer with watchdog mode: 8-bit auto-reload up-counter, APB slave.
// Assumes timebase_tick is a one-cycle enable from timebase logic on pclk, and
// that system reset logic drives presetn low for every system reset source.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module rtw_timer
  import rtw_pkg::*;
#(
  parameter int COUNT_W = CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timebase_tick,
  output logic overflow_irq,
  output logic system_reset_req
);

  // Register layout is fixed at eight bits; other widths are refused
  if (COUNT_W != CNT_W) begin : g_width_check
    $error("rtw_timer: COUNT_W must equal 8");
  end

  // Last prescaler value for each divide select code
  function automatic logic [PRE_W-1:0] div_last(input logic [2:0] sel);
    int ratio;
    case (sel)
      3'd0: ratio = DIV_0;
      3'd1: ratio = DIV_1;
      3'd2: ratio = DIV_2;
      3'd3: ratio = DIV_3;
      3'd4: ratio = DIV_4;
      3'd5: ratio = DIV_5;
      3'd6: ratio = DIV_6;
      default: ratio = DIV_7;
    endcase
    return PRE_W'(ratio - 1);
  endfunction

  // Register index match with aligned, in-range byte address
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == 2'h0) && (a[9:2] == idx);
  endfunction

  logic [COUNT_W-1:0] count_q; // Counter, no reset: undefined after reset
  logic [COUNT_W-1:0] reload_q; // Reload value, no reset either
  logic mode_q; // Watchdog mode selected
  logic run_bit_q; // Reload-mode run bit, plain storage in watchdog mode
  logic [2:0] div_sel_q; // Count clock divide select
  logic guard_run_q; // Watchdog counting has started
  logic next_code_q; // Zero: expect 3H next, one: expect CH next
  logic [PRE_W-1:0] pre_q; // Timebase prescaler
  logic [31:0] prdata_q; // Read data, captured in setup phase
  logic irq_q; // Overflow interrupt pulse
  logic sysrst_q; // Watchdog reset request pulse

  // Bus decode
  logic hit_count;
  logic hit_reload;
  logic hit_control;
  logic access;
  logic wr_low; // Write that reaches the low byte lane
  logic wr_count;
  logic wr_reload;
  logic wr_control;
  logic [3:0] wr_nib;

  assign hit_count = addr_hit(paddr, IDX_COUNT);
  assign hit_reload = addr_hit(paddr, IDX_RELOAD);
  assign hit_control = addr_hit(paddr, IDX_CONTROL);
  assign access = psel && penable;
  assign wr_low = access && pwrite && pstrb[0];
  assign wr_count = wr_low && hit_count;
  assign wr_reload = wr_low && hit_reload;
  assign wr_control = wr_low && hit_control;
  assign wr_nib = pwdata[3:0];

  // Zero wait states; unmapped addresses answer with an error
  assign pready = access;
  assign pslverr = access && !(hit_count || hit_reload || hit_control);
  assign prdata = prdata_q;
  assign overflow_irq = irq_q;
  assign system_reset_req = sysrst_q;

  // Counting enable, count tick and overflow
  logic counting;
  logic cnt_tick;
  logic at_top;
  logic ovf;
  logic guard_ovf;
  logic expect_code_ok;
  logic start_evt;
  logic svc_evt;
  logic [3:0] expected_nib;

  assign counting = mode_q ? guard_run_q : run_bit_q;
  assign cnt_tick = counting && timebase_tick && (pre_q == div_last(div_sel_q));
  assign at_top = (count_q == {COUNT_W{1'b1}});
  assign ovf = cnt_tick && at_top;
  // watchdog overflow, unless a service write lands in the same cycle
  assign guard_ovf = ovf && mode_q && !svc_evt;
  assign expected_nib = next_code_q ? CODE_SERVICE : CODE_START;
  assign expect_code_ok = (wr_nib == expected_nib);
  // first 3H in watchdog mode only starts counting
  assign start_evt = wr_count && mode_q && !guard_run_q && (wr_nib == CODE_START);
  // service needs the expected code while running
  assign svc_evt = wr_count && mode_q && guard_run_q && expect_code_ok;

  // Read data mux; only read side effect-free values are returned
  logic [7:0] ctl_view;
  always_comb begin
    // bit 4 reads one, others reflect state
    ctl_view = 8'h00;
    ctl_view[CTL_DIV_MSB:CTL_DIV_LSB] = div_sel_q;
    ctl_view[CTL_RUN_BIT] = run_bit_q;
    ctl_view[CTL_ONE_BIT] = 1'b1;
    ctl_view[CTL_GRUN_BIT] = mode_q && guard_run_q;
    ctl_view[CTL_NEXT_BIT] = next_code_q;
    ctl_view[CTL_MODE_BIT] = mode_q;
  end

  // Read data captured at setup so it comes from a flip-flop at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_count) begin
        prdata_q <= {24'h00_0000, count_q};
      end else if (hit_reload) begin
        prdata_q <= {24'h00_0000, reload_q};
      end else if (hit_control) begin
        prdata_q <= {24'h00_0000, ctl_view};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Control fields; a watchdog overflow returns them to reset state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= CTL_RESET[CTL_MODE_BIT];
      run_bit_q <= CTL_RESET[CTL_RUN_BIT];
      div_sel_q <= CTL_RESET[CTL_DIV_MSB:CTL_DIV_LSB];
    end else if (guard_ovf) begin
      // own overflow acts as a system reset here too
      mode_q <= CTL_RESET[CTL_MODE_BIT];
      run_bit_q <= CTL_RESET[CTL_RUN_BIT];
      div_sel_q <= CTL_RESET[CTL_DIV_MSB:CTL_DIV_LSB];
    end else if (wr_control) begin
      // mode bit can only be set; clearing is ignored
      mode_q <= mode_q || pwdata[CTL_MODE_BIT];
      run_bit_q <= pwdata[CTL_RUN_BIT];
      // divide select locked in watchdog mode
      // old mode decides, so one write sets both
      if (!mode_q) begin
        div_sel_q <= pwdata[CTL_DIV_MSB:CTL_DIV_LSB];
      end
    end
  end

  // Watchdog start and code sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_run_q <= 1'b0;
      next_code_q <= 1'b0;
    end else if (guard_ovf) begin
      guard_run_q <= 1'b0;
      next_code_q <= 1'b0;
    end else if (start_evt) begin
      guard_run_q <= 1'b1;
      next_code_q <= 1'b1;
    end else if (svc_evt) begin
      next_code_q <= !next_code_q;
    end
    // any other counter write leaves the sequence alone
  end

  // Prescaler restarts whenever counting stops so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (!counting) begin
      pre_q <= '0;
    end else if (timebase_tick) begin
      if (pre_q == div_last(div_sel_q)) begin
        pre_q <= '0;
      end else begin
        pre_q <= pre_q + PRE_W'(1);
      end
    end
  end

  // counter has no reset, contents undefined until written
  always_ff @(posedge pclk) begin
    if (svc_evt) begin
      count_q <= reload_q;
    end else if (wr_count && !mode_q) begin
      count_q <= pwdata[COUNT_W-1:0];
    end else if (ovf && !mode_q) begin
      // reload on overflow in reload mode
      count_q <= reload_q;
    end else if (cnt_tick && !at_top) begin
      count_q <= count_q + COUNT_W'(1);
    end
    // in watchdog mode plain counter writes change nothing
  end

  // Reload register, no reset
  always_ff @(posedge pclk) begin
    if (!mode_q && wr_count) begin
      reload_q <= pwdata[COUNT_W-1:0];
    end else if (!mode_q && wr_reload) begin
      reload_q <= pwdata[COUNT_W-1:0];
    end
  end

  // Event pulses to interrupt controller and system reset logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else begin
      irq_q <= ovf && !mode_q && !wr_count;
      // request system reset on watchdog overflow
      sysrst_q <= guard_ovf;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ctl_read_s;
    psel && !penable && !pwrite && hit_control ##1 psel && penable;
  endsequence

  sequence svc_s;
    svc_evt ##1 1'b1;
  endsequence

  cnt_incr_a: assert property (
    cnt_tick && !at_top && !wr_count |=> count_q == $past(count_q) + COUNT_W'(1))
    else $error("counter did not increment on tick");

  reload_ovf_a: assert property (
    ovf && !mode_q && !wr_count |=> overflow_irq && (count_q == $past(reload_q)))
    else $error("reload-mode overflow did not interrupt and reload");

  guard_ovf_a: assert property (
    ovf && mode_q && !svc_evt |=> system_reset_req ##1 !system_reset_req && !mode_q)
    else $error("watchdog overflow did not request one reset");

  start_keep_a: assert property (
    start_evt && !cnt_tick |=> guard_run_q && next_code_q && $stable(count_q))
    else $error("start code altered counter or failed to start");

  bad_code_a: assert property (
    wr_count && mode_q && guard_run_q && !expect_code_ok && !cnt_tick
    |=> $stable(next_code_q) && $stable(count_q))
    else $error("wrong service code had an effect");

  svc_load_a: assert property (
    svc_s |-> (count_q == $past(reload_q)) && (next_code_q != $past(next_code_q)))
    else $error("service write did not reload and toggle");

  reload_lock_a: assert property (
    mode_q && !guard_ovf |=> $stable(reload_q))
    else $error("reload value changed in watchdog mode");

  div_lock_a: assert property (
    mode_q && !guard_ovf |=> $stable(div_sel_q))
    else $error("divide select changed in watchdog mode");

  mode_stick_a: assert property (
    mode_q && !guard_ovf |=> mode_q)
    else $error("watchdog mode left without reset");

  bit4_one_a: assert property (
    ctl_read_s |-> prdata[CTL_ONE_BIT] && (prdata[CTL_GRUN_BIT] == $past(mode_q && guard_run_q)))
    else $error("control read shows wrong fixed or flag bit");

  irq_pulse_a: assert property (
    overflow_irq |-> !$past(mode_q) ##1 !overflow_irq)
    else $error("interrupt not a single reload-mode pulse");

  // Low byte of the write bus, so the mirror check can look one cycle back
  logic [COUNT_W-1:0] wr_byte;
  assign wr_byte = pwdata[COUNT_W-1:0];

  mirror_rel_a: assert property (
    wr_count && !mode_q |=> (count_q == $past(wr_byte)) && (reload_q == $past(wr_byte)))
    else $error("counter write did not reach counter and reload");

  next_flag_a: assert property (
    ctl_read_s |-> (prdata[CTL_NEXT_BIT] == $past(next_code_q)) && (prdata[CTL_MODE_BIT] == $past(mode_q)))
    else $error("control read shows wrong code or mode flag");

  cnt_lock_a: assert property (
    wr_count && mode_q && !svc_evt && !cnt_tick |=> $stable(count_q) && $stable(reload_q))
    else $error("counter write changed period in watchdog mode");

endmodule

// ### rtw_far_side.sv
// Far-side model: timebase tick source and system reset logic.
// Assumes one pclk domain; the bench gates ticks through tick_en.
`timescale 1ns/1ps
module rtw_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick_en,
  input wire logic system_reset_req,
  output logic timebase_tick,
  output int reset_seen
);
  // One tick per pclk while enabled, registered so it never races the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_tick <= 1'b0;
    end else begin
      timebase_tick <= tick_en;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_seen <= 0;
    end else if (system_reset_req === 1'b1) begin
      reset_seen <= reset_seen + 1;
    end
  end
endmodule

// ### testbench.sv
// Self-checking bench: APB master, read scoreboard, far-side model.
// Assumes zero-wait APB answers and registered one-cycle event pulses.
`timescale 1ns/1ps
module testbench;
  import rtw_pkg::*;
  localparam logic [ADDR_W-1:0] A_CNT = ADDR_W'({IDX_COUNT, 2'b00});
  localparam logic [ADDR_W-1:0] A_REL = ADDR_W'({IDX_RELOAD, 2'b00});
  localparam logic [ADDR_W-1:0] A_CTL = ADDR_W'({IDX_CONTROL, 2'b00});
  localparam logic [ADDR_W-1:0] A_BAD = 12'h004;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tick_en, tick, irq, sreq;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] v;
  logic [32:0] exp_q[$]; // Expected {pslverr, prdata} per read
  int bad_count, cmp_count, irq_n, n, n0, rst_seen;
  integer seed;
  int divs[8] = '{DIV_0, DIV_1, DIV_2, DIV_3, DIV_4, DIV_5, DIV_6, DIV_7};

  rtw_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_tick(tick), .overflow_irq(irq), .system_reset_req(sreq));
  rtw_far_side far_u (.pclk(pclk), .presetn(presetn), .tick_en(tick_en), .system_reset_req(sreq),
    .timebase_tick(tick), .reset_seen(rst_seen));

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Single comparison point, counted
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    cmp_count++;
    if (seen !== want) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic xfer(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  // Note the expectation, then read; the monitor compares
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask

  // Bounded wait for an event pulse, counting cycles
  task automatic wait_ev(input bit rq, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while ((rq ? sreq : irq) !== 1'b1 && cnt < lim);
  endtask

  // Read monitor: oldest note against the completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Interrupt pulse counter
  always @(posedge pclk) begin
    if (irq === 1'b1) begin
      irq_n <= irq_n + 1;
    end
  end

  // Watchdog against a hung run
  initial begin
    #(25 * 30000);
    bad_count++;
    conclude();
  end

  initial begin
    seed = 32'had1cdb8e;
    {psel, penable, pwrite, paddr, pwdata, tick_en, presetn} = '0;
    bad_count = 0;
    cmp_count = 0;
    irq_n = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTL, 33'h10);
    rd(A_BAD, 33'h1_0000_0000);
    wr(A_CTL, 8'h67);
    rd(A_CTL, 33'h17);
    repeat (4) begin
      v = 8'($random(seed));
      wr(A_CNT, v);
      rd(A_CNT, {25'h0, v});
      rd(A_REL, {25'h0, v});
    end
    wr(A_REL, 8'hA5);
    rd(A_REL, 33'hA5);
    $display("test registers done");
    tick_en <= 1'b1;
    // Overflow time per divide code, from a preset of FF
    for (int d = 0; d < 8; d++) begin
      wr(A_CNT, 8'hFF);
      wr(A_CTL, {5'h01, 3'(d)});
      wait_ev(1'b0, 5000, n);
      check({32'h0, n >= divs[d] && n <= divs[d] + 4}, 33'h1);
      @(posedge pclk);
      check({32'h0, irq}, 33'h0);
      wr(A_CTL, 8'h00);
      rd(A_CNT, 33'hFF);
    end
    // Run bit now clear with the fastest divide: a halted counter raises nothing
    n0 = irq_n;
    repeat (40) @(posedge pclk);
    check(33'(irq_n - n0), 33'h0);
    $display("test divide done");
    tick_en <= 1'b0;
    wr(A_CNT, 8'h80);
    wr(A_CTL, 8'h81);
    rd(A_CTL, 33'h91);
    wr(A_CTL, 8'h0F);
    rd(A_CTL, 33'h99);
    wr(A_CNT, 8'h5C);
    rd(A_CTL, 33'h99);
    wr(A_REL, 8'h11);
    rd(A_REL, 33'h80);
    wr(A_CNT, 8'hE3);
    rd(A_CNT, 33'h80);
    rd(A_CTL, 33'hF9);
    wr(A_CNT, 8'h23);
    rd(A_CTL, 33'hF9);
    tick_en <= 1'b1;
    repeat (100) @(posedge pclk);
    tick_en <= 1'b0;
    wr(A_CNT, 8'h7C);
    rd(A_CNT, 33'h80);
    rd(A_CTL, 33'hB9);
    wr(A_CNT, 8'h55);
    rd(A_CNT, 33'h80);
    n0 = irq_n;
    tick_en <= 1'b1;
    wait_ev(1'b1, 2300, n);
    check({32'h0, n > 127 * divs[1] && n <= 128 * divs[1] + 4}, 33'h1);
    repeat (2) @(posedge pclk);
    check(33'(rst_seen), 33'h1);
    check(33'(irq_n - n0), 33'h0);
    tick_en <= 1'b0;
    rd(A_CTL, 33'h10);
    $display("test watchdog done");
    conclude();
  end
endmodule
